// ### inc/mss_defs.vh
/*
 Constants for the message screen selector: register offsets, field layouts,
 reset values and memory geometry. Assumes inclusion by bare name.
*/
`ifndef MSS_DEFS_VH
`define MSS_DEFS_VH
`define MSS_NUM_SCREENS 16
`define MSS_SCR_BITS 4
`define MSS_WORDS_PER_SCREEN 36
`define MSS_ADDR_BITS 15
`define MSS_ADDR_MAX 15'h7FDC
`define MSS_ADDR_DEFAULT_BASE 15'h2328
`define MSS_ADDR_DEFAULT_STEP 15'h0028
`define MSS_CTRL_WORD_DEFAULT 9'h000
`define MSS_CTRL_WORD_BITS 9
// Register byte offsets
`define MSS_OFF_CTRL 12'h000
`define MSS_OFF_STATUS 12'h004
`define MSS_OFF_FETCH 12'h008
`define MSS_OFF_CFG_BASE 12'h040
`define MSS_OFF_ADDR_BASE 12'h080
// CFG register: bit 0 usage flag, bits 24:16 control word number
`define MSS_CFG_USE_BIT 0
`define MSS_CFG_WORD_LSB 16
`define MSS_CFG_WORD_MSB 24
// STATUS: bit 0 showing, bits 11:8 screen index (0 = screen one)
`define MSS_ST_SHOW_BIT 0
`define MSS_ST_SCR_LSB 8
`define MSS_ST_SCR_MSB 11
`define MSS_RESP_OKAY 2'h0
`define MSS_RESP_SLVERR 2'h2
`endif

// ### verilog/mss_selector.v
/*
 Message screen selector: sixteen screen configurations held in AXI4-Lite
 registers; picks the lowest-numbered enabled screen whose control bit is on
 and walks its 36-word text region through the data memory, driving the
 character pair of each word to the display side.
 Assumes the work relay words arrive on ctrl_word_in as selected by
 ctrl_word_sel, and data memory reads answer one cycle after the address.
*/
// The address map and the AXI4-Lite slave port are this design's own decisions.
// Functional notes
// - Sixteen separately configurable, deletable screen configurations
// - Show screen text only while control bit on
// - Screen n uses control word bit n-1
// - Control word from work area, default zero
// - Leading address 0..32732, default 9000+40(n-1)
// - Text spans 36 words from leading address
// - Usage flag Y enables, N ignores bit
// - Two characters per word, upper byte first
`timescale 1ns/1ps
`include "mss_defs.vh"
module mss_selector #(
    parameter NUM_SCREENS = `MSS_NUM_SCREENS,
    parameter WORDS_PER_SCREEN = `MSS_WORDS_PER_SCREEN
)(
    input wire mclk,
    input wire reset,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    output wire [8:0] ctrl_word_sel,
    input wire [15:0] ctrl_word_in,
    output wire [14:0] data_memory_area_addr,
    output wire data_memory_area_rd,
    input wire [15:0] data_memory_area_rdata,
    output wire disp_show,
    output wire [3:0] disp_screen,
    output wire [5:0] disp_word_idx,
    output wire [7:0] disp_char_hi,
    output wire [7:0] disp_char_lo,
    output wire disp_char_valid
);
    // Per-screen configuration, shared control word, enable and fetch counter
    reg [NUM_SCREENS-1:0] screen_usage_flag_q;
    reg [`MSS_ADDR_BITS-1:0] leading_word_setting_q [0:NUM_SCREENS-1];
    reg [`MSS_CTRL_WORD_BITS-1:0] ctrl_word_q;
    reg enable_q;
    reg [31:0] fetch_count_q;
    integer i;
    integer j;

    // AXI4-Lite slave state
    reg aw_held_q, w_held_q, bvalid_q, rvalid_q;
    reg [11:0] awaddr_q;
    reg [31:0] wdata_q, rdata_q;
    reg [1:0] bresp_q, rresp_q;
    // Strobes are kept with the data: the master may drop them once W is taken
    reg [3:0] wstrb_q;

    assign s_axi_awready = ~aw_held_q & ~bvalid_q;
    assign s_axi_wready = ~w_held_q & ~bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    wire do_write = aw_held_q & w_held_q & ~bvalid_q;
    wire wr_cfg = (awaddr_q[11:6] == `MSS_OFF_CFG_BASE >> 6);
    wire wr_adr = (awaddr_q[11:6] == `MSS_OFF_ADDR_BASE >> 6);
    wire [3:0] wr_idx = awaddr_q[5:2];
    wire [3:0] rd_idx = s_axi_araddr[5:2];
    wire [`MSS_ADDR_BITS-1:0] new_addr = wdata_q[`MSS_ADDR_BITS-1:0];

    // Selection: lowest set index among enabled screens with bit on
    reg found;
    reg [3:0] pick;
    always @*
    begin
        found = 1'b0;
        pick = 4'h0;
        for (i = NUM_SCREENS - 1; i >= 0; i = i - 1)
        begin
            if (screen_usage_flag_q[i] && ctrl_word_in[i])
            begin
                found = 1'b1;
                pick = i[3:0];
            end
        end
    end

    assign ctrl_word_sel = ctrl_word_q;

    // Text walker: restarts whenever the chosen screen changes
    reg show_q;
    reg [3:0] scr_q;
    reg [5:0] idx_q;
    reg rd_q;
    reg [5:0] rd_idx_q;
    // Memory answers a cycle after the address, so capture waits one stage
    reg ans_q;
    reg [5:0] ans_idx_q;
    reg [14:0] addr_q;
    reg [7:0] hi_q, lo_q;
    reg cv_q;
    wire active = enable_q & found;

    always @(posedge mclk)
    begin
        if (reset)
        begin
            show_q <= 1'b0;
            scr_q <= 4'h0;
            idx_q <= 6'h00;
            rd_q <= 1'b0;
            rd_idx_q <= 6'h00;
            ans_q <= 1'b0;
            ans_idx_q <= 6'h00;
            addr_q <= 15'h0000;
            hi_q <= 8'h00;
            lo_q <= 8'h00;
            cv_q <= 1'b0;
        end
        else
        begin
            show_q <= active;
            rd_q <= active;
            rd_idx_q <= idx_q;
            ans_q <= rd_q;
            ans_idx_q <= rd_idx_q;
            if (!active || !show_q || pick != scr_q)
            begin
                scr_q <= pick;
                idx_q <= 6'h00;
                rd_q <= 1'b0;
            end
            else
            begin
                // Region is a fixed 36-word span; wrap to keep refreshing
                if (idx_q == WORDS_PER_SCREEN - 1)
                    idx_q <= 6'h00;
                else
                    idx_q <= idx_q + 6'h01;
                addr_q <= leading_word_setting_q[scr_q] + {9'h000, idx_q};
            end
            cv_q <= ans_q & show_q;
            if (ans_q)
            begin
                hi_q <= data_memory_area_rdata[15:8];
                lo_q <= data_memory_area_rdata[7:0];
            end
        end
    end
    reg [5:0] out_idx_q;
    always @(posedge mclk)
    begin
        if (reset)
            out_idx_q <= 6'h00;
        else if (ans_q)
            out_idx_q <= ans_idx_q;
    end

    assign data_memory_area_addr = addr_q;
    assign data_memory_area_rd = rd_q;
    assign disp_show = show_q;
    assign disp_screen = scr_q;
    assign disp_word_idx = out_idx_q;
    assign disp_char_hi = hi_q;
    assign disp_char_lo = lo_q;
    assign disp_char_valid = cv_q;

    // Register write, configuration and counters
    always @(posedge mclk)
    begin
        if (reset)
        begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `MSS_RESP_OKAY;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            enable_q <= 1'b1;
            ctrl_word_q <= `MSS_CTRL_WORD_DEFAULT;
            screen_usage_flag_q <= {NUM_SCREENS{1'b0}};
            fetch_count_q <= 32'h00000000;
            for (j = 0; j < NUM_SCREENS; j = j + 1)
                leading_word_setting_q[j] <= `MSS_ADDR_DEFAULT_BASE
                    + j[`MSS_ADDR_BITS-1:0] * `MSS_ADDR_DEFAULT_STEP;
        end
        else
        begin
            if (cv_q)
                fetch_count_q <= fetch_count_q + 32'h00000001;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready)
                bvalid_q <= 1'b0;
            if (do_write)
            begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= `MSS_RESP_OKAY;
                if (awaddr_q == `MSS_OFF_CTRL)
                begin
                    if (wstrb_q[0])
                        enable_q <= wdata_q[0];
                end
                else if (awaddr_q == `MSS_OFF_STATUS || awaddr_q == `MSS_OFF_FETCH)
                    bresp_q <= `MSS_RESP_OKAY;
                else if (wr_cfg)
                begin
                    // Clearing the usage flag deletes the screen
                    if (wstrb_q[0])
                        screen_usage_flag_q[wr_idx] <= wdata_q[`MSS_CFG_USE_BIT];
                    if (wstrb_q[2] && wstrb_q[3] && wr_idx == 4'h0)
                        ctrl_word_q <= wdata_q[`MSS_CFG_WORD_MSB:`MSS_CFG_WORD_LSB];
                end
                else if (wr_adr)
                begin
                    // Out-of-range leading addresses are refused
                    if (new_addr > `MSS_ADDR_MAX || !(wstrb_q[0] && wstrb_q[1]))
                        bresp_q <= `MSS_RESP_SLVERR;
                    else
                        leading_word_setting_q[wr_idx] <= new_addr;
                end
                else
                    bresp_q <= `MSS_RESP_SLVERR;
            end
        end
    end

    // Register read
    always @(posedge mclk)
    begin
        if (reset)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `MSS_RESP_OKAY;
        end
        else if (rvalid_q)
        begin
            if (s_axi_rready)
                rvalid_q <= 1'b0;
        end
        else if (s_axi_arvalid)
        begin
            rvalid_q <= 1'b1;
            rresp_q <= `MSS_RESP_OKAY;
            rdata_q <= 32'h00000000;
            if (s_axi_araddr == `MSS_OFF_CTRL)
                rdata_q <= {31'h00000000, enable_q};
            else if (s_axi_araddr == `MSS_OFF_STATUS)
                rdata_q <= {20'h00000, scr_q, 7'h00, show_q};
            else if (s_axi_araddr == `MSS_OFF_FETCH)
                rdata_q <= fetch_count_q;
            else if (s_axi_araddr[11:6] == `MSS_OFF_CFG_BASE >> 6)
                rdata_q <= {7'h00, ctrl_word_q, 15'h0000, screen_usage_flag_q[rd_idx]};
            else if (s_axi_araddr[11:6] == `MSS_OFF_ADDR_BASE >> 6)
                rdata_q <= {17'h00000, leading_word_setting_q[rd_idx]};
            else
                rresp_q <= `MSS_RESP_SLVERR;
        end
    end
endmodule // mss_selector

// ### verification/mss_selector_props.sv
/* Checker for mss_selector port behaviour. Bound to every instance of the selector. */
`timescale 1ns/1ps
module mss_selector_chk #(
    parameter WORDS_PER_SCREEN = 36
)(
    input wire mclk,
    input wire reset,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [8:0] ctrl_word_sel,
    input wire [15:0] ctrl_word_in,
    input wire data_memory_area_rd,
    input wire [15:0] data_memory_area_rdata,
    input wire disp_show,
    input wire [3:0] disp_screen,
    input wire [5:0] disp_word_idx,
    input wire [7:0] disp_char_hi,
    input wire [7:0] disp_char_lo,
    input wire disp_char_valid
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    sequence s_ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_char;
        disp_char_valid;
    endsequence
    property p_char_lag;
        s_char |-> $past(data_memory_area_rd, 2);
    endproperty
    property p_char_data;
        s_char |-> {disp_char_hi, disp_char_lo} == $past(data_memory_area_rdata);
    endproperty
    property p_word_idx;
        s_char |-> disp_word_idx < WORDS_PER_SCREEN;
    endproperty
    property p_show_src;
        disp_show |-> ($past(ctrl_word_in) >> disp_screen) & 16'h0001;
    endproperty
    property p_show_off;
        ctrl_word_in == 16'h0000 |=> !disp_show;
    endproperty
    property p_sel_reset;
        $fell(reset) |-> ctrl_word_sel == 9'h000 && !disp_show;
    endproperty
    property p_rd_ans;
        s_ar_take |=> s_axi_rvalid;
    endproperty
    property p_b_once;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_char_lag: assert property (p_char_lag) else $error("char without address");
    a_char_data: assert property (p_char_data) else $error("char pair differs from word");
    a_word_idx: assert property (p_word_idx) else $error("word index past region");
    a_show_src: assert property (p_show_src) else $error("shown screen bit was off");
    a_show_off: assert property (p_show_off) else $error("shown with all bits off");
    a_sel_reset: assert property (p_sel_reset) else $error("bad state after reset");
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered"); 
    a_b_once: assert property (p_b_once) else $error("write answer repeated");
endmodule // mss_selector_chk
bind mss_selector mss_selector_chk #(.WORDS_PER_SCREEN(WORDS_PER_SCREEN)) u_chk (.*);

// ### verification/mss_mem_model.sv
/* Controller memory model: data words and one work word. Assumes the bench drives bits. */
`timescale 1ns/1ps
module mss_mem_model #(
    parameter [8:0] CTRL_WORD = 9'h064
)(
    input wire mclk,
    input wire [14:0] addr,
    input wire rd,
    input wire [8:0] word_sel,
    input wire [15:0] bits,
    output reg [15:0] rdata = 16'h0000,
    output wire [15:0] word_val
);
    // Released lines toggle so a late sample never matches by luck
    always @(posedge mclk)
    begin
        if (rd)
            rdata <= {1'b0, addr};
        else
            rdata <= ~rdata;
    end
    assign word_val = (word_sel == CTRL_WORD) ? bits : 16'h0000;
endmodule // mss_mem_model

// ### verification/tb.sv
/* Bench for mss_selector over AXI4-Lite. Assumes the model answers reads next cycle. */
`timescale 1ns/1ps
module tb;
    reg mclk = 0, reset = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    reg [11:0] awa = 12'h000, ara = 12'h000;
    reg [31:0] wd = 32'h0;
    reg [3:0] ws = 4'h0;
    reg [15:0] bits = 16'h0000;
    wire awr, wr, bv, arr, rv, rd, show, cv;
    wire [1:0] br, rr;
    wire [31:0] rdat;
    wire [8:0] sel;
    wire [15:0] wrd, md;
    wire [14:0] ma;
    wire [3:0] scr;
    wire [5:0] idx;
    wire [7:0] hi, lo;
    integer error_cnt = 0, total_checks = 0, k;
    integer cv_seen = 0;
    mss_selector dut (.mclk(mclk), .reset(reset), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .ctrl_word_sel(sel),
        .ctrl_word_in(wrd), .data_memory_area_addr(ma), .data_memory_area_rd(rd), .data_memory_area_rdata(md),
        .disp_show(show), .disp_screen(scr), .disp_word_idx(idx), .disp_char_hi(hi), .disp_char_lo(lo),
        .disp_char_valid(cv));
    mss_mem_model mem (.mclk(mclk), .addr(ma), .rd(rd), .word_sel(sel), .bits(bits), .rdata(md), .word_val(wrd));
    initial
    begin
        forever #2.5 mclk = ~mclk;
    end
    // Words seen on the display side, to hold the delivered-word counter against
    always @(posedge mclk)
        if (!reset && cv)
            cv_seen <= cv_seen + 1;
    task test_done;
    begin
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
        total_checks = total_checks + 1;
        if (e !== g)
        begin
            error_cnt = error_cnt + 1;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    end
    endtask
    task stuck(input h);
    begin
        if (!h)
        begin
            chk("wait", 32'h1, 32'h0);
            test_done;
        end
    end
    endtask
    // Handshakes are read mid-cycle; the readies only move at rising edges
    task axi_wr(input [11:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
        integer i;
        reg ha, hw, hb;
    begin
        awa <= a;
        wd <= d;
        ws <= s;
        awv <= 1;
        wv <= 1;
        bry <= 1;
        hb = 0;
        for (i = 0; i < 40 && !hb; i = i + 1)
        begin
            @(negedge mclk);
            ha = awv && awr;
            hw = wv && wr;
            hb = bv;
            if (hb)
                chk("bresp", er, br);
            @(posedge mclk);
            if (ha)
                awv <= 0;
            if (hw)
                wv <= 0;
        end
        stuck(hb);
    end
    endtask
    task axi_rd(input [11:0] a, input [31:0] ed, input [1:0] er);
        integer i;
        reg ha, hr;
    begin
        ara <= a;
        arv <= 1;
        rry <= 1;
        hr = 0;
        for (i = 0; i < 40 && !hr; i = i + 1)
        begin
            @(negedge mclk);
            ha = arv && arr;
            hr = rv;
            if (hr)
            begin
                chk("rresp", er, rr);
                chk("rdata", ed, rdat);
            end
            @(posedge mclk);
            if (ha)
                arv <= 0;
        end
        stuck(hr);
    end
    endtask
    task pick(input [15:0] v, input s, input [3:0] n);
    begin
        bits <= v;
        repeat (4) @(negedge mclk);
        chk("show", s, show);
        if (s)
            chk("screen", n, scr);
        @(posedge mclk);
    end
    endtask
    task text(input [14:0] base);
        integer i, w;
        reg [5:0] nxt;
    begin
        nxt = 6'h00;
        for (i = 0; i < 40; i = i + 1)
        begin
            w = 0;
            do
            begin
                @(negedge mclk);
                w = w + 1;
            end
            while (!cv && w < 20);
            stuck(cv);
            if (i > 0)
                chk("index", nxt, idx);
            chk("text", {1'b0, base + {9'h000, idx}}, {hi, lo});
            nxt = (idx == 6'h23) ? 6'h00 : idx + 6'h01;
        end
        @(posedge mclk);
    end
    endtask
    initial
    begin
        repeat (8) @(posedge mclk);
        reset <= 0;
        axi_rd(12'h000, 32'h1, 2'h0);
        for (k = 0; k < 16; k = k + 1)
            axi_rd(12'(12'h080 + 4 * k), 32'(16'h2328 + 16'h28 * k), 2'h0);
        axi_rd(12'h044, 32'h0, 2'h0);
        axi_rd(12'h0C0, 32'h0, 2'h2);
        axi_wr(12'h0C0, 32'h1, 4'hF, 2'h2);
        axi_wr(12'h040, 32'h0064_0000, 4'hF, 2'h0);
        chk("sel", 32'h64, {23'h0, sel});
        axi_rd(12'h07C, 32'h0064_0000, 2'h0);
        axi_wr(12'h090, 32'h7FDD, 4'hF, 2'h2);
        axi_rd(12'h090, 32'h23C8, 2'h0);
        axi_wr(12'h090, 32'h7FDC, 4'hF, 2'h0);
        axi_wr(12'h048, 32'h1, 4'h1, 2'h0);
        axi_wr(12'h050, 32'h1, 4'h1, 2'h0);
        pick(16'h0012, 1, 4'h4);
        text(15'h7FDC);
        pick(16'h0016, 1, 4'h2);
        axi_rd(12'h004, 32'h0201, 2'h0);
        text(15'h2378);
        axi_wr(12'h048, 32'h0, 4'h1, 2'h0);
        pick(16'h0016, 1, 4'h4);
        axi_wr(12'h004, 32'hF, 4'hF, 2'h0);
        pick(16'h0000, 0, 4'h0);
        axi_rd(12'h008, cv_seen, 2'h0);
        axi_wr(12'h000, 32'h0, 4'h1, 2'h0);
        pick(16'h0010, 0, 4'h0);
        axi_rd(12'h000, 32'h0, 2'h0);
        test_done;
    end
endmodule // tb
